/* tx_cfg_pkg.sv */
// Purpose: Shared constants and types for the transmit control register block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Threshold byte tables are plain defaults, adjustable here
package tx_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TRANSMIT_CONFIG = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_HARDWARE_CONFIG = 8'h74;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h7C;
  localparam int TXC_STATUS_FLUSH = 15;
  localparam int TXC_DATA_FLUSH = 14;
  localparam int TXC_OVERRUN_ALLOW = 2;
  localparam int TXC_TX_ENABLE = 1;
  localparam int TXC_STOP_REQ = 0;
  localparam int HWC_THR_MODE = 21;
  localparam int HWC_SF = 20;
  localparam int HWC_THR_LO = 12;
  localparam int IRQ_W = 3;
  localparam int IRQ_STATUS_FULL = 0;
  localparam int IRQ_TX_STOPPED = 1;
  localparam int IRQ_UNDERRUN = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] THR_FIELD_RESET = 2'h0;
  localparam int BYTES_W = 14;
  typedef logic [BYTES_W-1:0] byte_count_t;
  typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SEND, TX_SUSP} tx_state_t;
  // Start points in buffered bytes, one table per threshold mode
  localparam byte_count_t THR_TAB0 [4] = '{14'h0040, 14'h0080, 14'h0100, 14'h0200};
  localparam byte_count_t THR_TAB1 [4] = '{14'h0010, 14'h0020, 14'h0040, 14'h0080};

  function automatic byte_count_t thr_bytes(input logic mode, input logic [1:0] field);
    return mode ? THR_TAB1[field] : THR_TAB0[field];
  endfunction
endpackage

/* tx_gate_if.sv */
// Purpose: Carries start-gate settings and buffer fill to the start decision
// Assumes: Single clock domain
// Notes: Purely combinational bundle
`timescale 1ns/100ps
interface tx_gate_if;
  import tx_cfg_pkg::*;
  logic store_and_forward;
  logic threshold_mode;
  logic [1:0] threshold_field;
  byte_count_t data_bytes;
  logic whole_frame;
  logic start_ok;
  modport ctrl (output store_and_forward, threshold_mode, threshold_field, data_bytes, whole_frame,
    input start_ok);
  modport gate (input store_and_forward, threshold_mode, threshold_field, data_bytes, whole_frame,
    output start_ok);
endinterface // tx_gate_if

/* tx_start_gate.sv */
// Purpose: Decides when buffered data is enough to start a frame
// Assumes: whole_frame means a complete frame sits in the buffer
// Notes: A complete frame always qualifies, even below threshold
`timescale 1ns/100ps
module tx_start_gate
  import tx_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  tx_gate_if.gate g
);
  byte_count_t level;

  always_comb begin
    level = thr_bytes(g.threshold_mode, g.threshold_field);
    if (g.store_and_forward) begin
      g.start_ok = g.whole_frame;
    end else begin
      g.start_ok = g.whole_frame || (g.data_bytes >= level);
    end
  end

  property p_sf_whole;
    @(posedge pclk) disable iff (!presetn) g.store_and_forward && g.start_ok |-> g.whole_frame;
  endproperty
  a_sf_whole: assert property (p_sf_whole) else $error("start without whole frame in store-and-forward");

  property p_cut_through;
    @(posedge pclk) disable iff (!presetn)
      !g.store_and_forward && g.data_bytes >= thr_bytes(g.threshold_mode, g.threshold_field) |-> g.start_ok;
  endproperty
  a_cut_through: assert property (p_cut_through) else $error("threshold reached but start withheld");
endmodule // tx_start_gate

/* tx_irq_ctrl.sv */
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: Events are one-cycle pulses on pclk
// Notes: An event in the clearing cycle survives the clear
`timescale 1ns/100ps
module tx_irq_ctrl
  import tx_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [IRQ_W-1:0] events,
  input wire logic status_we,
  input wire logic mask_we,
  input wire logic [IRQ_W-1:0] wdata,
  output logic [IRQ_W-1:0] status_r,
  output logic [IRQ_W-1:0] mask_r,
  output logic irq
);
  logic [IRQ_W-1:0] status_nxt;
  logic [IRQ_W-1:0] mask_nxt;

  always_comb begin
    status_nxt = (status_we ? (status_r & ~wdata) : status_r) | events;
    mask_nxt = mask_we ? wdata : mask_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      mask_r <= IRQ_MASK_RESET;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn) |events |=> ((status_r & $past(events)) == $past(events));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in status");
endmodule // tx_irq_ctrl

/* tx_control_config_regs.sv */
// Purpose: Transmit configuration and hardware configuration registers with transmit control
// Assumes: MAC side signals share pclk; frame_done follows frame_start by at least one cycle
// Notes: APB slave, zero wait states, read data registered in setup phase
//
// Behaviour
// - Writing one to status flush clears status FIFO pointers, bit self-clears
// - Writing one to data flush clears data FIFO pointers, bit self-clears
// - Without overrun allow, a full status FIFO suspends transmission
// - Status FIFO full interrupt is independent of overrun allow
// - Transmit enable lets buffered frames go; cleared means transmitter idle
// - Transmit enable clears itself once stop is requested and transmitter halted
// - Stop request finishes current frame, halts, then clears itself
// - Writes to the stop request bit are ignored while it is set
// - Store-and-forward waits for a whole frame, thresholds ignored
// - Without store-and-forward, start at threshold before frame is complete
// - Threshold mode picks the threshold table, ignored in store-and-forward
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module tx_control_config_regs
  import tx_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire byte_count_t tx_data_bytes,
  input wire logic tx_whole_frame,
  input wire logic status_fifo_full,
  input wire logic frame_done,
  input wire logic tx_underrun,
  output logic frame_start,
  output logic tx_active,
  output logic tx_status_flush,
  output logic tx_data_flush,
  output logic store_and_forward,
  output logic threshold_mode,
  output logic [1:0] threshold_field,
  output logic irq
);
  tx_state_t state_r, state_nxt;
  logic stop_r, stop_nxt;
  logic tx_on_r, tx_on_nxt;
  logic allow_r, allow_nxt;
  logic sflush_r, sflush_nxt;
  logic dflush_r, dflush_nxt;
  logic start_r, start_nxt;
  logic sf_r, sf_nxt;
  logic ttm_r, ttm_nxt;
  logic [1:0] thr_r, thr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic full_d_r;
  logic hit, wr, wr_txc, wr_hwc, wr_sts, wr_msk, en_wr;
  logic suspend_cond, halt;
  logic [IRQ_W-1:0] events, irq_status, irq_mask;

  tx_gate_if gif ();

  // APB decode
  always_comb begin
    hit = (paddr == OFS_TRANSMIT_CONFIG) || (paddr == OFS_HARDWARE_CONFIG) ||
          (paddr == OFS_INT_STATUS) || (paddr == OFS_INT_MASK);
    wr = psel && penable && pwrite && hit;
    wr_txc = wr && (paddr == OFS_TRANSMIT_CONFIG);
    wr_hwc = wr && (paddr == OFS_HARDWARE_CONFIG);
    wr_sts = wr && (paddr == OFS_INT_STATUS);
    wr_msk = wr && (paddr == OFS_INT_MASK);
    en_wr = pwdata[TXC_TX_ENABLE];
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;

  // Transmit control state machine and configuration bits
  always_comb begin
    suspend_cond = status_fifo_full && !allow_r;
    halt = 1'b0;
    state_nxt = state_r;
    start_nxt = 1'b0;
    stop_nxt = stop_r;
    tx_on_nxt = tx_on_r;
    allow_nxt = allow_r;
    sflush_nxt = 1'b0;
    dflush_nxt = 1'b0;
    sf_nxt = sf_r;
    ttm_nxt = ttm_r;
    thr_nxt = thr_r;
    if (wr_txc) begin
      sflush_nxt = pwdata[TXC_STATUS_FLUSH];
      dflush_nxt = pwdata[TXC_DATA_FLUSH];
      allow_nxt = pwdata[TXC_OVERRUN_ALLOW];
      tx_on_nxt = pwdata[TXC_TX_ENABLE];
      if (!stop_r) begin
        stop_nxt = pwdata[TXC_STOP_REQ];
      end
    end
    if (wr_hwc) begin
      sf_nxt = pwdata[HWC_SF];
      ttm_nxt = pwdata[HWC_THR_MODE];
      thr_nxt = pwdata[HWC_THR_LO +: 2];
    end
    unique case (state_r)
      TX_OFF: begin
        if (stop_r) begin
          halt = 1'b1;
        end else if (tx_on_r) begin
          state_nxt = TX_IDLE;
        end
      end
      TX_IDLE: begin
        if (stop_r) begin
          halt = 1'b1;
        end else if (!tx_on_r) begin
          state_nxt = TX_OFF;
        end else if (suspend_cond) begin
          state_nxt = TX_SUSP;
        end else if (gif.start_ok) begin
          state_nxt = TX_SEND;
          start_nxt = 1'b1;
        end
      end
      TX_SEND: begin
        // A running frame is never cut short
        if (frame_done) begin
          if (stop_r) begin
            halt = 1'b1;
          end else if (!tx_on_r) begin
            state_nxt = TX_OFF;
          end else if (suspend_cond) begin
            state_nxt = TX_SUSP;
          end else begin
            state_nxt = TX_IDLE;
          end
        end
      end
      TX_SUSP: begin
        if (stop_r) begin
          halt = 1'b1;
        end else if (!tx_on_r) begin
          state_nxt = TX_OFF;
        end else if (!suspend_cond) begin
          state_nxt = TX_IDLE;
        end
      end
    endcase
    if (halt) begin
      state_nxt = TX_OFF;
      stop_nxt = 1'b0;
      tx_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TX_OFF;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      tx_on_r <= 1'b0;
      allow_r <= 1'b0;
      sflush_r <= 1'b0;
      dflush_r <= 1'b0;
      sf_r <= 1'b0;
      ttm_r <= 1'b0;
      thr_r <= THR_FIELD_RESET;
    end else begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      tx_on_r <= tx_on_nxt;
      allow_r <= allow_nxt;
      sflush_r <= sflush_nxt;
      dflush_r <= dflush_nxt;
      sf_r <= sf_nxt;
      ttm_r <= ttm_nxt;
      thr_r <= thr_nxt;
    end
  end

  // Read data captured in setup phase, so the access phase needs no wait
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = '0;
      unique case (paddr)
        OFS_TRANSMIT_CONFIG: begin
          prdata_nxt[TXC_STATUS_FLUSH] = sflush_r;
          prdata_nxt[TXC_DATA_FLUSH] = dflush_r;
          prdata_nxt[TXC_OVERRUN_ALLOW] = allow_r;
          prdata_nxt[TXC_TX_ENABLE] = tx_on_r;
          prdata_nxt[TXC_STOP_REQ] = stop_r;
        end
        OFS_HARDWARE_CONFIG: begin
          prdata_nxt[HWC_THR_MODE] = ttm_r;
          prdata_nxt[HWC_SF] = sf_r;
          prdata_nxt[HWC_THR_LO +: 2] = thr_r;
        end
        OFS_INT_STATUS: prdata_nxt[IRQ_W-1:0] = irq_status;
        OFS_INT_MASK: prdata_nxt[IRQ_W-1:0] = irq_mask;
        default: prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      full_d_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      full_d_r <= status_fifo_full;
    end
  end

  // Full event ignores overrun allow on purpose
  always_comb begin
    events = '0;
    events[IRQ_STATUS_FULL] = status_fifo_full && !full_d_r;
    events[IRQ_TX_STOPPED] = halt;
    events[IRQ_UNDERRUN] = tx_underrun;
  end

  assign gif.store_and_forward = sf_r;
  assign gif.threshold_mode = ttm_r;
  assign gif.threshold_field = thr_r;
  assign gif.data_bytes = tx_data_bytes;
  assign gif.whole_frame = tx_whole_frame;

  tx_start_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .g(gif.gate)
  );

  tx_irq_ctrl u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(events),
    .status_we(wr_sts),
    .mask_we(wr_msk),
    .wdata(pwdata[IRQ_W-1:0]),
    .status_r(irq_status),
    .mask_r(irq_mask),
    .irq(irq)
  );

  assign frame_start = start_r;
  assign tx_active = (state_r == TX_SEND);
  assign tx_status_flush = sflush_r;
  assign tx_data_flush = dflush_r;
  assign store_and_forward = sf_r;
  assign threshold_mode = ttm_r;
  assign threshold_field = thr_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  property p_status_flush;
    wr_txc && pwdata[TXC_STATUS_FLUSH] |=> s_one_pulse(tx_status_flush);
  endproperty
  a_status_flush: assert property (p_status_flush) else $error("status flush pulse wrong");

  property p_data_flush;
    wr_txc && pwdata[TXC_DATA_FLUSH] |=> s_one_pulse(tx_data_flush);
  endproperty
  a_data_flush: assert property (p_data_flush) else $error("data flush pulse wrong");

  property p_no_start_when_full;
    frame_start |-> !$past(suspend_cond);
  endproperty
  a_no_start_when_full: assert property (p_no_start_when_full) else $error("frame started on full status");

  property p_full_irq;
    $rose(status_fifo_full) |=> irq_status[IRQ_STATUS_FULL];
  endproperty
  a_full_irq: assert property (p_full_irq) else $error("full event not recorded");

  property p_start_needs_enable;
    frame_start |-> $past(tx_on_r) && $past(state_r) == TX_IDLE;
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("frame started while disabled");

  property p_halt_clears;
    stop_r && state_r != TX_SEND |=> !stop_r && !tx_on_r && state_r == TX_OFF;
  endproperty
  a_halt_clears: assert property (p_halt_clears) else $error("halt did not clear enable and stop");

  sequence s_frame_open;
    state_r == TX_SEND && !frame_done;
  endsequence

  property p_stop_finishes;
    // Software may rewrite enable mid-frame; only a halt must not touch it
    s_frame_open |=> state_r == TX_SEND && tx_on_r == ($past(wr_txc) ? $past(en_wr) : $past(tx_on_r));
  endproperty
  a_stop_finishes: assert property (p_stop_finishes) else $error("frame cut before done");

  property p_stop_ignored;
    stop_r && state_r == TX_SEND && !frame_done |=> stop_r;
  endproperty
  a_stop_ignored: assert property (p_stop_ignored) else $error("stop bit dropped early");

  property p_resume;
    state_r == TX_SUSP && !status_fifo_full && tx_on_r && !stop_r |=> state_r == TX_IDLE;
  endproperty
  a_resume: assert property (p_resume) else $error("suspended transmitter did not resume");

  property p_reserved_zero;
    psel && penable && !pwrite && paddr == OFS_TRANSMIT_CONFIG |-> prdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
endmodule // tx_control_config_regs

/* mac_side_model.sv */
// Purpose: Behavioural MAC and FIFO side facing the transmit control block
// Assumes: One pclk domain; done_dly of at least 1
// Notes: Sends frame_done done_dly+1 cycles after each frame_start; counts flush pulses
`timescale 1ns/100ps
module mac_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_start,
  input wire logic tx_status_flush,
  input wire logic tx_data_flush,
  input wire logic [7:0] done_dly,
  output logic frame_done,
  output logic [7:0] sflush_cnt,
  output logic [7:0] dflush_cnt
);
  logic [7:0] left_r;
  logic busy_r;
  // Floor of one cycle keeps frame_done strictly after frame_start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 8'h00;
      busy_r <= 1'b0;
      frame_done <= 1'b0;
      sflush_cnt <= 8'h00;
      dflush_cnt <= 8'h00;
    end else begin
      frame_done <= 1'b0;
      if (frame_start) begin
        busy_r <= 1'b1;
        left_r <= (done_dly > 8'h01) ? done_dly - 8'h01 : 8'h00;
      end else if (busy_r && left_r == 8'h00) begin
        busy_r <= 1'b0;
        frame_done <= 1'b1;
      end else if (busy_r) begin
        left_r <= left_r - 8'h01;
      end
      if (tx_status_flush) begin
        sflush_cnt <= sflush_cnt + 8'h01;
      end
      if (tx_data_flush) begin
        dflush_cnt <= dflush_cnt + 8'h01;
      end
    end
  end
endmodule // mac_side_model

/* tb_tx_control_config_regs.sv */
// Purpose: Self-checking bench for the transmit control register block
// Assumes: Zero wait state APB slave; MAC side played by mac_side_model
// Notes: Start detection uses fixed windows of a few cycles
`timescale 1ns/100ps
module tb_tx_control_config_regs
  import tx_cfg_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, frame_done, frame_start, tx_active, tx_status_flush, tx_data_flush;
  logic store_and_forward, threshold_mode, irq, tx_whole_frame = 1'b0, status_fifo_full = 1'b0;
  logic tx_underrun = 1'b0;
  logic [1:0] threshold_field;
  byte_count_t tx_data_bytes = '0;
  logic [7:0] done_dly = 8'h02, sflush_cnt, dflush_cnt;
  logic [31:0] r;
  logic e;
  int error_cnt = 0, checked = 0, start_cnt = 0;

  always #10 pclk = ~pclk;

  tx_control_config_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_data_bytes(tx_data_bytes), .tx_whole_frame(tx_whole_frame),
    .status_fifo_full(status_fifo_full), .frame_done(frame_done), .tx_underrun(tx_underrun),
    .frame_start(frame_start), .tx_active(tx_active), .tx_status_flush(tx_status_flush),
    .tx_data_flush(tx_data_flush), .store_and_forward(store_and_forward),
    .threshold_mode(threshold_mode), .threshold_field(threshold_field), .irq(irq));

  mac_side_model mac_u (.pclk(pclk), .presetn(presetn), .frame_start(frame_start),
    .tx_status_flush(tx_status_flush), .tx_data_flush(tx_data_flush), .done_dly(done_dly),
    .frame_done(frame_done), .sflush_cnt(sflush_cnt), .dflush_cnt(dflush_cnt));

  always @(posedge pclk) begin
    if (frame_start === 1'b1) begin
      start_cnt++;
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb_xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0);
    check(r & m, exp);
  endtask

  task automatic expect_start(input logic exp);
    int c0;
    c0 = start_cnt;
    repeat (8) @(posedge pclk);
    check({31'h0, start_cnt != c0}, {31'h0, exp});
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdchk(OFS_TRANSMIT_CONFIG + 8'(4 * i), 32'hFFFFFFFF, 32'h0);
    end
    check({31'h0, irq}, 32'h0);
    wr(OFS_HARDWARE_CONFIG, 32'hFFFFFFFF);
    rdchk(OFS_HARDWARE_CONFIG, 32'hFFFFFFFF, 32'h00303000);
    check({28'h0, store_and_forward, threshold_mode, threshold_field}, 32'hF);
    wr(OFS_TRANSMIT_CONFIG, 32'hFFFF3FF8);
    rdchk(OFS_TRANSMIT_CONFIG, 32'hFFFFFFFF, 32'h0);
    wr(OFS_TRANSMIT_CONFIG, 32'h00008000);
    rdchk(OFS_TRANSMIT_CONFIG, 32'hFFFFFFFF, 32'h0);
    check({sflush_cnt, dflush_cnt}, 32'h0100);
    wr(OFS_TRANSMIT_CONFIG, 32'h00004000);
    rdchk(OFS_TRANSMIT_CONFIG, 32'hFFFFFFFF, 32'h0);
    check({sflush_cnt, dflush_cnt}, 32'h0101);
    wr(8'h40, 32'h12345678);
    rdchk(8'h40, 32'hFFFFFFFF, 32'h0);
    check({31'h0, e}, 32'h1);
    // Threshold start, 100 Mbps setting then 10 Mbps setting
    wr(OFS_HARDWARE_CONFIG, 32'h00001000);
    wr(OFS_TRANSMIT_CONFIG, 32'h00000002);
    tx_data_bytes <= THR_TAB0[1] - 14'h0001;
    expect_start(1'b0);
    tx_data_bytes <= THR_TAB0[1];
    expect_start(1'b1);
    tx_data_bytes <= '0;
    wr(OFS_HARDWARE_CONFIG, 32'h00201000);
    tx_data_bytes <= THR_TAB1[1];
    expect_start(1'b1);
    tx_data_bytes <= '0;
    wr(OFS_HARDWARE_CONFIG, 32'h00301000);
    tx_data_bytes <= 14'h3FFF;
    expect_start(1'b0);
    tx_whole_frame <= 1'b1;
    expect_start(1'b1);
    tx_data_bytes <= '0;
    wr(OFS_TRANSMIT_CONFIG, 32'h00000000);
    // A frame launched just before the disable lands must drain first
    repeat (8) @(posedge pclk);
    expect_start(1'b0);
    tx_whole_frame <= 1'b0;
    // Suspend on a full status FIFO, then resume
    wr(OFS_HARDWARE_CONFIG, 32'h00001000);
    wr(OFS_INT_MASK, 32'h00000001);
    wr(OFS_TRANSMIT_CONFIG, 32'h00000002);
    status_fifo_full <= 1'b1;
    tx_data_bytes <= THR_TAB0[1];
    expect_start(1'b0);
    check({31'h0, irq}, 32'h1);
    status_fifo_full <= 1'b0;
    expect_start(1'b1);
    tx_data_bytes <= '0;
    wr(OFS_INT_STATUS, 32'h00000007);
    rdchk(OFS_INT_STATUS, 32'h00000001, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(OFS_TRANSMIT_CONFIG, 32'h00000006);
    status_fifo_full <= 1'b1;
    tx_data_bytes <= THR_TAB0[1];
    expect_start(1'b1);
    rdchk(OFS_INT_STATUS, 32'h00000001, 32'h1);
    status_fifo_full <= 1'b0;
    tx_data_bytes <= '0;
    wr(OFS_INT_MASK, 32'h00000000);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    tx_underrun <= 1'b1;
    @(posedge pclk);
    tx_underrun <= 1'b0;
    rdchk(OFS_INT_STATUS, 32'h00000004, 32'h4);
    // Stop request in mid-frame; slow MAC side
    wr(OFS_INT_STATUS, 32'h00000007);
    done_dly <= 8'h1E;
    wr(OFS_TRANSMIT_CONFIG, 32'h00000002);
    tx_data_bytes <= THR_TAB0[1];
    expect_start(1'b1);
    tx_data_bytes <= '0;
    wr(OFS_TRANSMIT_CONFIG, 32'h00000003);
    rdchk(OFS_TRANSMIT_CONFIG, 32'hFFFFFFFF, 32'h3);
    check({31'h0, tx_active}, 32'h1);
    wr(OFS_TRANSMIT_CONFIG, 32'h00000002);
    rdchk(OFS_TRANSMIT_CONFIG, 32'hFFFFFFFF, 32'h3);
    repeat (40) @(posedge pclk);
    rdchk(OFS_TRANSMIT_CONFIG, 32'hFFFFFFFF, 32'h0);
    check({31'h0, tx_active}, 32'h0);
    rdchk(OFS_INT_STATUS, 32'h00000002, 32'h2);
    summarize();
  end

  // Whole run is well under 3000 cycles
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule // tb_tx_control_config_regs
